// ### bps_regs.vh
`ifndef BPS_REGS_VH
`define BPS_REGS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define BPS_ADR_CTRL      4'h0
`define BPS_ADR_POL       4'h4
`define BPS_ADR_DELAY     4'h8
`define BPS_ADR_STATUS    4'hc

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define BPS_CTRL_LOOP     0
`define BPS_CTRL_TSRC     1
`define BPS_CTRL_PH90     2
`define BPS_CTRL_PREEMP   3
`define BPS_CTRL_ODSKIP   4
`define BPS_CTRL_TIMEU    5
`define BPS_CTRL_W        6
// Loopback off, group bus source, no shift, no pre-emphasis
`define BPS_CTRL_RST      6'h02

// ----------------------------------------------------------------
// Polarity register fields
// ----------------------------------------------------------------
`define BPS_POL_RXCLK     0
`define BPS_POL_RXDRST    1
`define BPS_POL_RXRST     2
`define BPS_POL_TXCLK     3
`define BPS_POL_TXDRST    4
`define BPS_POL_TXRST     5
`define BPS_POL_W         6
`define BPS_POL_RST       6'h00

// ----------------------------------------------------------------
// Delay register fields
// ----------------------------------------------------------------
`define BPS_DLY_TX_LSB    0
`define BPS_DLY_RX_LSB    8
`define BPS_DLY_RST       5'h00

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define BPS_STAT_RXBIT    0
`define BPS_STAT_TXBIT    1
`define BPS_STAT_TRI      2
`define BPS_STAT_PHERR    3
`define BPS_STAT_CALLSB   4

// Serial output level out of reset
`define BPS_TX_INIT       1'b1

`endif

// ### bps_delay_line.v
`include "bps_regs.vh"

// Tapped delay line: tap 0 passes the input with one register stage
module bps_delay_line #(
    parameter DEPTH = 32,
    parameter TAP_W = 5
) (
    input  wire             clk_i,
    input  wire             rst_i,
    input  wire             din_i,
    input  wire [TAP_W-1:0] tap_i,
    output reg              dout_o
);
    reg  [DEPTH-1:0] stage_ff;
    wire [DEPTH-1:0] nxt_stage;

    genvar g;
    generate
        for (g = 0; g < DEPTH; g = g + 1)
        begin : g_stage
            if (g == 0)
            begin : g_first
                assign nxt_stage[g] = din_i;
            end
            else
            begin : g_next
                assign nxt_stage[g] = stage_ff[g-1];
            end
        end
    endgenerate

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stage_ff <= {DEPTH{1'b0}};
            dout_o   <= 1'b0;
        end
        else
        begin
            stage_ff <= nxt_stage;
            if (tap_i == {TAP_W{1'b0}})
                dout_o <= din_i;
            else
                dout_o <= stage_ff[tap_i - 1'b1];
        end
    end
endmodule // bps_delay_line

// ### bps_slice.v
`include "bps_regs.vh"

// How it works
// - Loopback on: transmitted serial output returns as receive input.
// - Loop runs transmit serial output (delay line, or skip stage when skip is on) into receive delay input.
// - Group source: tristate output follows controller's four-bit group bus.
// - Per-slice source: tristate input passed through; fabric generates it.
// - Phase option set shifts transmit output a quarter bit; clear, none.
// - Pre-emphasis enable, default off, drives pad buffer pre-emphasis.
// - Receive clock inverted when its polarity bit is one.
// - Receive delay reset inverted when its polarity bit is one.
// - Receive reset inverted through local inverter when bit is one.
// - Transmit clock inverted when its polarity bit is one.
// - Transmit delay reset inverted when its polarity bit is one.
// - Transmit reset inverted through local inverter when bit is one.
// - Output delay skip routes transmit data around delay line; default off.
// - Calibrated time units reserve slices of the nibble for calibration.
// - Polarity inversion happens inside the slice, no extra fabric logic.
module bps_slice #(
    parameter DLY_DEPTH = 32,
    parameter TAP_W     = 5,
    parameter SLOT      = 0,
    parameter QUARTER   = 1,
    parameter CAL_MASK  = 4'h1
) (
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Slice side signals
    input  wire        receive_clock_i,
    input  wire        receive_reset_i,
    input  wire        receive_delay_reset_i,
    input  wire        transmit_clock_i,
    input  wire        transmit_reset_i,
    input  wire        transmit_delay_reset_i,
    input  wire        tx_data_i,
    input  wire        tristate_i,
    input  wire [3:0]  group_tristate_bus_i,
    output reg         rx_data_o,
    // Pad buffer side
    input  wire        pad_receive_input_i,
    output reg         pad_out_o,
    output reg         pad_oe_n_o,
    output reg         pre_emphasis_o,
    output reg  [3:0]  cal_reserved_o
);

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    reg  [`BPS_CTRL_W-1:0] ctrl_ff;
    reg  [`BPS_POL_W-1:0]  pol_ff;
    reg  [TAP_W-1:0]       tx_tap_ff;
    reg  [TAP_W-1:0]       rx_tap_ff;
    reg  [31:0]            nxt_rdata;
    reg  [31:0]            status;

    wire wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wb_wr   = wb_req & wb_we_i;
    wire loop_en = ctrl_ff[`BPS_CTRL_LOOP];
    wire grp_src = ctrl_ff[`BPS_CTRL_TSRC];
    wire ph90    = ctrl_ff[`BPS_CTRL_PH90];
    wire od_skip = ctrl_ff[`BPS_CTRL_ODSKIP];

    // ------------------------------------------------------------
    // Local polarity inverters
    // ------------------------------------------------------------
    // Plain XOR on each incoming line, nothing else in between
    wire rxclk_eff = receive_clock_i ^ pol_ff[`BPS_POL_RXCLK];
    wire rxdrst    = receive_delay_reset_i
                     ^ pol_ff[`BPS_POL_RXDRST];
    wire rxrst     = receive_reset_i ^ pol_ff[`BPS_POL_RXRST];
    wire txclk_eff = transmit_clock_i ^ pol_ff[`BPS_POL_TXCLK];
    wire txdrst    = transmit_delay_reset_i
                     ^ pol_ff[`BPS_POL_TXDRST];
    wire txrst     = transmit_reset_i ^ pol_ff[`BPS_POL_TXRST];

    // ------------------------------------------------------------
    // Clock edge detection
    // ------------------------------------------------------------
    // Slice clocks arrive as levels; rising edges act as strobes
    reg  rxclk_ff;
    reg  txclk_ff;
    wire rx_edge = rxclk_eff & ~rxclk_ff;
    wire tx_edge = txclk_eff & ~txclk_ff;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            // Track the pin level so release brings no false edge
            rxclk_ff <= rxclk_eff;
            txclk_ff <= txclk_eff;
        end
        else
        begin
            rxclk_ff <= rxclk_eff;
            txclk_ff <= txclk_eff;
        end
    end

    // ------------------------------------------------------------
    // Transmit bit and quarter-bit shift
    // ------------------------------------------------------------
    reg             tx_bit_ff;
    reg [QUARTER:0] ph_pipe_ff;

    always @(posedge clk_i)
    begin
        if (rst_i | txrst)
            tx_bit_ff <= `BPS_TX_INIT;
        else if (tx_edge)
            tx_bit_ff <= tx_data_i;
    end

    always @(posedge clk_i)
    begin
        if (rst_i | txrst)
            ph_pipe_ff <= {(QUARTER+1){`BPS_TX_INIT}};
        else
            ph_pipe_ff <= {ph_pipe_ff[QUARTER-1:0], tx_bit_ff};
    end

    // Extra stage only when shifting, so the unshifted path is not delayed
    wire tx_phased = ph90 ? ph_pipe_ff[QUARTER-1] : tx_bit_ff;

    // ------------------------------------------------------------
    // Delay lines and loopback
    // ------------------------------------------------------------
    wire tx_dly_out;
    wire rx_dly_out;

    bps_delay_line #(
        .DEPTH (DLY_DEPTH),
        .TAP_W (TAP_W)
    ) u_out_dly (
        .clk_i  (clk_i),
        .rst_i  (rst_i | txdrst),
        .din_i  (tx_phased),
        .tap_i  (tx_tap_ff),
        .dout_o (tx_dly_out)
    );

    // Skip bypasses the taps but keeps one stage for equal latency
    reg  tx_skip_ff;
    wire tx_serial = od_skip ? tx_skip_ff : tx_dly_out;

    always @(posedge clk_i)
    begin
        if (rst_i)
            tx_skip_ff <= `BPS_TX_INIT;
        else
            tx_skip_ff <= tx_phased;
    end

    // Loop closes after the output delay, before the input delay
    wire rx_src = loop_en ? tx_serial
                          : pad_receive_input_i;

    bps_delay_line #(
        .DEPTH (DLY_DEPTH),
        .TAP_W (TAP_W)
    ) u_in_dly (
        .clk_i  (clk_i),
        .rst_i  (rst_i | rxdrst),
        .din_i  (rx_src),
        .tap_i  (rx_tap_ff),
        .dout_o (rx_dly_out)
    );

    // ------------------------------------------------------------
    // Receive capture and pad outputs
    // ------------------------------------------------------------
    wire tri_sel = grp_src ? group_tristate_bus_i[SLOT]
                           : tristate_i;

    always @(posedge clk_i)
    begin
        if (rst_i | rxrst)
            rx_data_o <= 1'b0;
        else if (rx_edge)
            rx_data_o <= rx_dly_out;
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pad_out_o      <= `BPS_TX_INIT;
            pad_oe_n_o     <= 1'b1;
            pre_emphasis_o <= 1'b0;
            cal_reserved_o <= 4'h0;
        end
        else
        begin
            // Pad output stays driven in loopback; pad input is ignored
            pad_out_o      <= tx_serial;
            pad_oe_n_o     <= tri_sel;
            pre_emphasis_o <= ctrl_ff[`BPS_CTRL_PREEMP];
            cal_reserved_o <= ctrl_ff[`BPS_CTRL_TIMEU]
                              ? CAL_MASK : 4'h0;
        end
    end

    // ------------------------------------------------------------
    // Status
    // ------------------------------------------------------------
    // Delays must be zero under the phase option; flag it, not enforce
    wire ph_err = ph90 & ((tx_tap_ff != {TAP_W{1'b0}})
                        | (rx_tap_ff != {TAP_W{1'b0}}));

    always @*
    begin
        status                    = 32'h0000_0000;
        status[`BPS_STAT_RXBIT]   = rx_data_o;
        status[`BPS_STAT_TXBIT]   = pad_out_o;
        status[`BPS_STAT_TRI]     = pad_oe_n_o;
        status[`BPS_STAT_PHERR]   = ph_err;
        status[`BPS_STAT_CALLSB+3:`BPS_STAT_CALLSB] = cal_reserved_o;
    end

    // ------------------------------------------------------------
    // Wishbone register access
    // ------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_ff   <= `BPS_CTRL_RST;
            pol_ff    <= `BPS_POL_RST;
            tx_tap_ff <= `BPS_DLY_RST;
            rx_tap_ff <= `BPS_DLY_RST;
        end
        else if (wb_wr)
        begin
            if (wb_adr_i == `BPS_ADR_CTRL)
            begin
                if (wb_sel_i[0])
                    ctrl_ff <= wb_dat_i[`BPS_CTRL_W-1:0];
            end
            else if (wb_adr_i == `BPS_ADR_POL)
            begin
                if (wb_sel_i[0])
                    pol_ff <= wb_dat_i[`BPS_POL_W-1:0];
            end
            else if (wb_adr_i == `BPS_ADR_DELAY)
            begin
                if (wb_sel_i[0])
                    tx_tap_ff <= wb_dat_i[`BPS_DLY_TX_LSB+TAP_W-1:
                                          `BPS_DLY_TX_LSB];
                if (wb_sel_i[1])
                    rx_tap_ff <= wb_dat_i[`BPS_DLY_RX_LSB+TAP_W-1:
                                          `BPS_DLY_RX_LSB];
            end
        end
    end

    always @*
    begin
        nxt_rdata = 32'h0000_0000;
        if (wb_adr_i == `BPS_ADR_CTRL)
            nxt_rdata[`BPS_CTRL_W-1:0] = ctrl_ff;
        else if (wb_adr_i == `BPS_ADR_POL)
            nxt_rdata[`BPS_POL_W-1:0] = pol_ff;
        else if (wb_adr_i == `BPS_ADR_DELAY)
        begin
            nxt_rdata[`BPS_DLY_TX_LSB+TAP_W-1:`BPS_DLY_TX_LSB] = tx_tap_ff;
            nxt_rdata[`BPS_DLY_RX_LSB+TAP_W-1:`BPS_DLY_RX_LSB] = rx_tap_ff;
        end
        else if (wb_adr_i == `BPS_ADR_STATUS)
            nxt_rdata = status;
    end

    // One wait state; unmapped addresses ack with zero data
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? nxt_rdata : 32'h0000_0000;
        end
    end
endmodule // bps_slice

// ### bps_slice_chk.sv
module bps_slice_chk #(
    parameter CAL_MASK = 4'h1
) (
    input wire        clk_i,
    input wire        rst_i,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        tristate_i,
    input wire [3:0]  group_tristate_bus_i,
    input wire        rx_data_o,
    input wire        pad_out_o,
    input wire        pad_oe_n_o,
    input wire        pre_emphasis_o,
    input wire [3:0]  cal_reserved_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_resp;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("ack missing");
    property p_ack_cause;
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
    property p_dat_idle;
        !wb_ack_o |-> wb_dat_o == 32'h0;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("data not zero");

    // ------------------------------------------------------------
    // Slice outputs
    // ------------------------------------------------------------
    property p_rst_vals;
        disable iff (1'b0) rst_i |=> pad_oe_n_o && pad_out_o &&
            !pre_emphasis_o && cal_reserved_o == 4'h0 && !rx_data_o;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("reset values");
    // Both sources agree, so the output is known in either mode
    property p_tri_follow;
        (tristate_i == group_tristate_bus_i[0])[*3]
            |-> pad_oe_n_o == tristate_i;
    endproperty
    a_tri_follow: assert property (p_tri_follow)
        else $error("tristate output wrong");
    property p_pre_src;
        $changed(pre_emphasis_o) |-> $past(wb_cyc_i && wb_we_i) ||
            $past(wb_cyc_i && wb_we_i, 2);
    endproperty
    a_pre_src: assert property (p_pre_src)
        else $error("pre-emphasis changed alone");
    property p_cal_val;
        cal_reserved_o == 4'h0 || cal_reserved_o == CAL_MASK;
    endproperty
    a_cal_val: assert property (p_cal_val)
        else $error("calibration mask wrong");

    c_write: cover property (wb_ack_o && wb_we_i);
    c_pre: cover property (pre_emphasis_o);
    c_drive: cover property (!pad_oe_n_o);
endmodule // bps_slice_chk

// ### bps_pad_model.sv
// Bidirectional pad: reads back the slice while driven, else the line
module bps_pad_model (
    input  wire  pad_out_i,
    input  wire  pad_oe_n_i,
    input  wire  pre_emphasis_i,
    input  logic ext_drive_i,
    output logic pad_level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    assign pad_level_o = pad_oe_n_i ? ext_drive_i : pad_out_i;
endmodule // bps_pad_model

// ### bps_tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0;
    logic        we = 1'b0, rxc = 1'b1, txc = 1'b1, txd = 1'b1;
    logic        tri_s = 1'b1, ext = 1'b0, zero = 1'b0;
    logic [3:0]  adr = 4'h0, bus = 4'hf;
    logic [31:0] wdat = 32'h0, rd;
    wire  [31:0] wb_dat_o;
    wire  [3:0]  cal_reserved_o;
    wire         wb_ack_o, rx_data_o, pad_out_o, pad_oe_n_o;
    wire         pre_emphasis_o, pad_in;
    int          n_mismatch = 0, cmp_count = 0;

    initial forever #4 clk_i = ~clk_i;

    bps_slice u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .receive_clock_i(rxc), .receive_reset_i(zero),
        .receive_delay_reset_i(zero), .transmit_clock_i(txc),
        .transmit_reset_i(zero), .transmit_delay_reset_i(zero),
        .tx_data_i(txd), .tristate_i(tri_s), .group_tristate_bus_i(bus),
        .rx_data_o(rx_data_o), .pad_receive_input_i(pad_in),
        .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o),
        .pre_emphasis_o(pre_emphasis_o), .cal_reserved_o(cal_reserved_o));
    bps_pad_model u_pad (.pad_out_i(pad_out_o), .pad_oe_n_i(pad_oe_n_o),
        .pre_emphasis_i(pre_emphasis_o), .ext_drive_i(ext),
        .pad_level_o(pad_in));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task final_report;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1)
                break;
        end
        chk("ack", 1, {31'h0, wb_ack_o});
        rd = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (i == 20)
            final_report();
    endtask
    task rdchk(input logic [3:0] a, input logic [31:0] exp, input string nm);
        wb(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask
    // Selects 0 pad_out_o, 1 rx_data_o, 2 pad_oe_n_o
    task wait_sig(input int sel, input logic exp, input string nm);
        int i;
        logic v;
        for (i = 0; i < 40; i++)
        begin
            @(posedge clk_i);
            v = sel == 0 ? pad_out_o : sel == 1 ? rx_data_o : pad_oe_n_o;
            if (v === exp)
                break;
        end
        chk(nm, {31'h0, exp}, {31'h0, v});
        if (v !== exp)
            final_report();
    endtask
    // Spaced toggles leave the delay lines time to settle
    task tog(input int which);
        repeat (3) @(posedge clk_i);
        if (which == 0)
            txc <= ~txc;
        else
            rxc <= ~rxc;
        repeat (3) @(posedge clk_i);
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        final_report();
    end

    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        chk("pins", 32'hc0, {24'h0, pad_oe_n_o, pad_out_o, pre_emphasis_o,
            cal_reserved_o, rx_data_o});
        rdchk(4'h0, 32'h2, "ctrl");
        rdchk(4'h4, 32'h0, "pol");
        rdchk(4'h8, 32'h0, "delay");
        rdchk(4'hc, 32'h6, "status");
        wb(1'b1, 4'h6, 32'hffff);
        rdchk(4'h6, 32'h0, "unmapped");
        bus <= 4'he;
        wait_sig(2, 1'b0, "oe_n group");
        wb(1'b1, 4'h0, 32'h0);
        wait_sig(2, 1'b1, "oe_n own");
        tri_s <= 1'b0;
        wait_sig(2, 1'b0, "oe_n own low");
        txd <= 1'b0;
        tog(0);
        tog(0);
        wait_sig(0, 1'b0, "pad_out");
        tri_s <= 1'b1;
        ext <= 1'b1;
        tog(1);
        tog(1);
        wait_sig(1, 1'b1, "rx pad");
        wb(1'b1, 4'h0, 32'h1);
        tog(1);
        tog(1);
        wait_sig(1, 1'b0, "rx loop 0");
        ext <= 1'b0;
        txd <= 1'b1;
        tog(0);
        tog(0);
        tog(1);
        tog(1);
        wait_sig(1, 1'b1, "rx loop 1");
        wb(1'b1, 4'h4, 32'h4);
        wait_sig(1, 1'b0, "rx rst pol");
        wb(1'b1, 4'h4, 32'h10);
        wait_sig(0, 1'b0, "tx dly rst pol");
        wb(1'b1, 4'h4, 32'h0);
        wait_sig(0, 1'b1, "tx dly rst off");
        txd <= 1'b0;
        wb(1'b1, 4'h4, 32'h8);
        repeat (8) @(posedge clk_i);
        chk("tx clk fall", 1, {31'h0, pad_out_o});
        tog(0);
        wait_sig(0, 1'b0, "tx clk pol");
        wb(1'b1, 4'h4, 32'h28);
        wait_sig(0, 1'b1, "tx rst pol");
        wb(1'b1, 4'h4, 32'h1);
        repeat (8) @(posedge clk_i);
        chk("rx clk fall", 0, {31'h0, rx_data_o});
        tog(1);
        wait_sig(1, 1'b1, "rx clk pol");
        wb(1'b1, 4'h4, 32'h3);
        tog(1);
        tog(1);
        wait_sig(1, 1'b0, "rx dly rst pol");
        wb(1'b1, 4'h0, 32'h28);
        repeat (2) @(posedge clk_i);
        chk("pre_emphasis", 1, {31'h0, pre_emphasis_o});
        chk("cal", 32'h1, {28'h0, cal_reserved_o});
        wb(1'b1, 4'h8, 32'h1);
        wb(1'b1, 4'h0, 32'h4);
        wb(1'b0, 4'hc, 32'h0);
        chk("phase flag", 32'h8, rd & 32'h8);
        // Delays back to zero before the phase option carries data
        wb(1'b1, 4'h8, 32'h0);
        tog(0);
        @(posedge clk_i);
        chk("phase hold", 1, {31'h0, pad_out_o});
        @(posedge clk_i);
        chk("phase shift", 0, {31'h0, pad_out_o});
        wb(1'b1, 4'h0, 32'h0);
        txd <= 1'b1;
        tog(0);
        tog(0);
        @(posedge clk_i);
        chk("no shift", 1, {31'h0, pad_out_o});
        // Long tap, so only the skip path can arrive this early
        wb(1'b1, 4'h8, 32'h10);
        wb(1'b1, 4'h0, 32'h10);
        txd <= 1'b0;
        tog(0);
        tog(0);
        @(posedge clk_i);
        chk("skip", 0, {31'h0, pad_out_o});
        repeat (16) @(posedge clk_i);
        wb(1'b1, 4'h0, 32'h0);
        txd <= 1'b1;
        tog(0);
        tog(0);
        @(posedge clk_i);
        chk("tap delay", 0, {31'h0, pad_out_o});
        wait_sig(0, 1'b1, "tap out");
        final_report();
    end
endmodule // tb

bind bps_slice bps_slice_chk #(.CAL_MASK(CAL_MASK)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .tristate_i(tristate_i), .group_tristate_bus_i(group_tristate_bus_i),
    .rx_data_o(rx_data_o), .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o),
    .pre_emphasis_o(pre_emphasis_o), .cal_reserved_o(cal_reserved_o));
